// File: hdl/sfsp_port.sv
`timescale 1ns/1ps
module sfsp_port (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic chip_select_low,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   output logic [15:0] mem_addr,
   output logic [4:0] mem_blk,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata
);
   logic [2:0] sclk_q;
   logic [1:0] cs_q;
   logic [1:0] mosi_q;
   sfsp_pkg::sfsp_phase_t phase_r, phase_nxt;
   logic [2:0] bit_cnt_r;
   logic [7:0] shin_r;
   logic [15:0] addr_r, addr_nxt;
   logic rw_r;
   logic [1:0] om_r;
   logic [2:0] left_r;
   logic [7:0] txsh_r;
   logic load_r;

   // every pin is foreign to core_clk; the first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sclk_q <= sfsp_pkg::SCLK_SYNC_RST;
         cs_q <= sfsp_pkg::CS_SYNC_RST;
         mosi_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], sclk};
         cs_q <= {cs_q[0], chip_select_low};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   // edges only, so modes 0 and 3 look alike regardless of idle level
   wire sclk_rise = sclk_q[1] & ~sclk_q[2];
   wire sclk_fall = ~sclk_q[1] & sclk_q[2];
   wire deselect = cs_q[1];
   wire mosi_s = mosi_q[1];
   wire [7:0] rx_byte = {shin_r[6:0], mosi_s};
   wire byte_done = sclk_rise & (bit_cnt_r == sfsp_pkg::BIT_LAST) & ~deselect;
   wire in_data = (phase_r == sfsp_pkg::SFSP_DATA);
   wire in_ctrl = (phase_r == sfsp_pkg::SFSP_CTRL);
   wire data_done = byte_done & in_data;
   wire ctrl_done = byte_done & in_ctrl;
   wire is_read = (rw_r == sfsp_pkg::RW_READ);
   wire fixed = (om_r != sfsp_pkg::OM_VAR);
   wire last_fixed = fixed & (left_r == sfsp_pkg::LEFT_ONE);
   wire [15:0] addr_inc = addr_r + 16'h0001;
   wire ctrl_read = (rx_byte[sfsp_pkg::RW_BIT] == sfsp_pkg::RW_READ);
   // prefetch the next byte unless a fixed frame is on its last one
   wire read_issue = (ctrl_done & ctrl_read) | (data_done & is_read & ~last_fixed);
   wire write_issue = data_done & ~is_read;
   wire [2:0] left_nxt = ctrl_done ? sfsp_pkg::sfsp_fix_len(rx_byte[1:0]) :
                         (data_done & fixed) ? left_r - 3'h1 : left_r;

   // frame phase sequencing; chip select high always returns to the start
   always_comb begin
      phase_nxt = phase_r;
      if (deselect) begin
         phase_nxt = sfsp_pkg::SFSP_ADDR_HI;
      end else if (byte_done) begin
         unique case (phase_r)
            sfsp_pkg::SFSP_ADDR_HI: phase_nxt = sfsp_pkg::SFSP_ADDR_LO;
            sfsp_pkg::SFSP_ADDR_LO: phase_nxt = sfsp_pkg::SFSP_CTRL;
            sfsp_pkg::SFSP_CTRL: phase_nxt = sfsp_pkg::SFSP_DATA;
            sfsp_pkg::SFSP_DATA: begin
               // fixed frames end by count since chip select need not rise
               phase_nxt = last_fixed ? sfsp_pkg::SFSP_ADDR_HI : sfsp_pkg::SFSP_DATA;
            end
         endcase
      end
   end

   // offset assembly, high byte first, then auto increment per data byte
   always_comb begin
      addr_nxt = addr_r;
      if (byte_done && phase_r == sfsp_pkg::SFSP_ADDR_HI) begin
         addr_nxt = {rx_byte, addr_r[7:0]};
      end else if (byte_done && phase_r == sfsp_pkg::SFSP_ADDR_LO) begin
         addr_nxt = {addr_r[15:8], rx_byte};
      end else if (data_done) begin
         addr_nxt = addr_inc;
      end
   end

   // receive shifter; a partial byte is dropped when chip select rises
   always_ff @(posedge core_clk) begin
      if (!reset_n || deselect) begin
         bit_cnt_r <= 3'h0;
         shin_r <= 8'h00;
      end else if (sclk_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shin_r <= rx_byte;
      end
   end

   // frame state and latched control fields
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         phase_r <= sfsp_pkg::SFSP_ADDR_HI;
         addr_r <= 16'h0000;
         rw_r <= 1'h0;
         om_r <= 2'h0;
         left_r <= 3'h0;
      end else begin
         phase_r <= phase_nxt;
         addr_r <= addr_nxt;
         left_r <= left_nxt;
         if (ctrl_done) begin
            rw_r <= rx_byte[sfsp_pkg::RW_BIT];
            om_r <= rx_byte[sfsp_pkg::OM_MSB:sfsp_pkg::OM_LSB];
         end
      end
   end

   // memory strobes; block select steers which block the offset targets
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mem_addr <= 16'h0000;
         mem_blk <= 5'h00;
         mem_wdata <= 8'h00;
         mem_we <= 1'h0;
         mem_re <= 1'h0;
         load_r <= 1'h0;
      end else begin
         mem_we <= write_issue;
         mem_re <= read_issue;
         load_r <= mem_re;
         if (ctrl_done) begin
            mem_blk <= rx_byte[sfsp_pkg::BSB_MSB:sfsp_pkg::BSB_LSB];
         end
         if (write_issue) begin
            mem_addr <= addr_r;
            mem_wdata <= rx_byte;
         end else if (read_issue) begin
            mem_addr <= in_data ? addr_inc : addr_r;
         end
      end
   end

   // transmit shifter: the byte lands long before the next falling edge
   // because one serial clock period spans dozens of core cycles
   always_ff @(posedge core_clk) begin
      if (!reset_n || deselect) begin
         txsh_r <= 8'h00;
         miso <= 1'h0;
         miso_oe <= 1'h0;
      end else begin
         miso_oe <= 1'h1;
         if (load_r) begin
            txsh_r <= mem_rdata;
         end else if (sclk_fall && in_data && is_read) begin
            miso <= txsh_r[7];
            txsh_r <= {txsh_r[6:0], 1'h0};
         end
      end
   end

   // helper for the length check: data bytes done in the current frame,
   // saturating so a fixed frame that overruns its count cannot wrap back into range
   logic [2:0] seen_r;
   always_ff @(posedge core_clk) begin
      if (!reset_n || deselect || ctrl_done) begin
         seen_r <= 3'h0;
      end else if (data_done && seen_r != 3'h7) begin
         seen_r <= seen_r + 3'h1;
      end
   end

   // protocol checks; all sample on core_clk and pause while in reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_oe_follows_cs: assert property (miso_oe == !$past(deselect))
      else $error("data out enable does not track chip select");
   chk_miso_fall_only: assert property ($changed(miso) && !$past(deselect) |-> $past(sclk_fall))
      else $error("data out changed away from a falling edge");
   chk_write_dir: assert property (mem_we |-> $past(sclk_rise) && !is_read)
      else $error("write strobe without a received write byte");
   chk_read_dir: assert property (mem_re && $past(in_data) |-> is_read)
      else $error("read strobe in a write frame");
   chk_abort_restart: assert property (deselect |=> phase_r == sfsp_pkg::SFSP_ADDR_HI
      && bit_cnt_r == 3'h0)
      else $error("deselect did not restart the frame");
   chk_addr_incr: assert property (data_done |=> addr_r == $past(addr_r) + 16'h0001)
      else $error("offset did not advance by one");
   chk_fixed_end: assert property (data_done && last_fixed |=> phase_r == sfsp_pkg::SFSP_ADDR_HI)
      else $error("fixed frame did not end after its byte count");
   chk_phase_order: assert property (byte_done && phase_r == sfsp_pkg::SFSP_ADDR_LO
      |=> phase_r == sfsp_pkg::SFSP_CTRL ##0 mem_blk == $past(mem_blk))
      else $error("address phase not followed by control phase");
   chk_read_load: assert property (mem_re |=> load_r ##1 txsh_r == $past(mem_rdata))
      else $error("read data not loaded into the transmitter");
   // strobes, field latching, output parking, bit counting and fixed frame length
   chk_strobe_excl: assert property (!(mem_we && mem_re))
      else $error("read and write strobes in one cycle");
   chk_blk_latch: assert property (ctrl_done |=> mem_blk == $past(rx_byte[7:3]))
      else $error("block select not taken from the control byte");
   chk_miso_idle: assert property (!miso_oe |-> miso == 1'h0)
      else $error("data out not parked low while released");
   chk_bit_step: assert property (sclk_rise && !deselect |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1)
      else $error("bit counter did not step on a rising edge");
   chk_left_count: assert property (data_done && fixed |=> left_r == $past(left_r) - 3'h1)
      else $error("fixed byte count did not step down");
   chk_fixed_len: assert property (data_done && fixed |-> seen_r < sfsp_pkg::sfsp_fix_len(om_r))
      else $error("fixed frame ran past its byte count");

   cov_write: cover property (mem_we ##[1:300] mem_we);
   cov_read: cover property (mem_re ##[1:300] mem_re);
   cov_fixed_end: cover property (data_done && last_fixed);
   cov_abort: cover property (!deselect && bit_cnt_r != 3'h0 ##1 deselect);
   cov_var_read_end: cover property (in_data && is_read && !fixed ##1 deselect);
endmodule // sfsp_port

// File: hdl/sfsp_pkg.sv
// Notes on behaviour
// - acts only as slave on chip select, serial clock, data in, data out
// - clock modes 0 and 3 only; idle clock level does not matter
// - sample on rising serial clock edge, change output on falling edge
// - every byte travels most significant bit first on both data lines
// - frame is address phase, then control phase, then data phase
// - address phase carries a 16-bit offset, high byte first
// - control byte: block select [7:3], direction bit [2], op mode [1:0]
// - block select tells which register or buffer block the offset hits
// - data phase is variable length or fixed 1, 2 or 4 bytes by op mode
// - chip select falling starts a frame; rising ends the data phase
// - first byte at the offset, each following byte at offset plus one
// - data out driven only while chip select is low, else released
package sfsp_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned BLK_W = 5;
   localparam int unsigned CNT_W = 3;
   // control byte field positions
   localparam int unsigned BSB_MSB = 7;
   localparam int unsigned BSB_LSB = 3;
   localparam int unsigned RW_BIT = 2;
   localparam int unsigned OM_MSB = 1;
   localparam int unsigned OM_LSB = 0;
   // direction and operating mode codes
   localparam logic RW_READ = 1'h0;
   localparam logic [1:0] OM_VAR = 2'h0;
   localparam logic [1:0] OM_FIX1 = 2'h1;
   localparam logic [1:0] OM_FIX2 = 2'h2;
   localparam logic [1:0] OM_FIX4 = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] LEFT_ONE = 3'h1;
   // sync stage reset values: chip select idles high (deselected)
   localparam logic [2:0] SCLK_SYNC_RST = 3'h0;
   localparam logic [1:0] CS_SYNC_RST = 2'h3;

   typedef enum logic [1:0] {
      SFSP_ADDR_HI,
      SFSP_ADDR_LO,
      SFSP_CTRL,
      SFSP_DATA
   } sfsp_phase_t;

   // data byte count of a fixed length frame, zero for variable length
   function automatic logic [2:0] sfsp_fix_len(input logic [1:0] om);
      logic [2:0] n;
      n = 3'h0;
      unique case (om)
         OM_FIX1: n = 3'h1;
         OM_FIX2: n = 3'h2;
         OM_FIX4: n = 3'h4;
         default: n = 3'h0;
      endcase
      return n;
   endfunction
endpackage

// File: verif/sfsp_master.sv
`timescale 1ns/1ps
module sfsp_master (
   input wire logic core_clk,
   output logic sclk,
   output logic chip_select_low,
   output logic mosi,
   input wire logic miso
);
   // idle deselected; the core sync needs a quiet select after reset
   initial begin
      sclk = 1'b0;
      chip_select_low = 1'b1;
      mosi = 1'b0;
   end
   // half period of 16 core cycles, 80 ns
   task automatic half();
      repeat (16) @(posedge core_clk);
   endtask
   // idle clock level picks mode 0 or mode 3
   task automatic sel(input logic idle);
      sclk <= idle;
      half();
      chip_select_low <= 1'b0;
   endtask
   // n bits msb first: drive on the fall, sample on the rise
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         half();
         sclk <= 1'b0;
         mosi <= tx[i];
         half();
         sclk <= 1'b1;
         rx[i] = miso;
      end
   endtask
   task automatic desel(input logic idle);
      half();
      sclk <= idle;
      half();
      chip_select_low <= 1'b1;
      mosi <= ~mosi; // no stale value left on the data line
   endtask
endmodule // sfsp_master

// File: verif/tb_spi_frame_slave_port.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_spi_frame_slave_port;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic sclk, chip_select_low, mosi, miso, miso_oe, mem_we, mem_re;
   wire miso_w;
   logic [15:0] mem_addr;
   logic [15:0] last_addr = 16'h0000;
   logic [4:0] mem_blk;
   logic [4:0] last_blk = 5'h00;
   logic [7:0] mem_wdata, rx;
   logic [7:0] mem_rdata = 8'h00;
   logic [7:0] mem [0:255];
   int num_errors = 0;
   int num_checks = 0;
   int wcnt = 0;
   logic idle_lvl = 1'b0;
   always #2.5 core_clk = ~core_clk;
   // the pin has no pull, so a released line shows the inverse of miso, which is parked low
   assign miso_w = miso_oe ? miso : ~miso;
   sfsp_port sfsp_port_inst (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk),
      .chip_select_low(chip_select_low), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .mem_addr(mem_addr), .mem_blk(mem_blk), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .mem_re(mem_re), .mem_rdata(mem_rdata));
   sfsp_master sfsp_master_inst (.core_clk(core_clk), .sclk(sclk),
      .chip_select_low(chip_select_low), .mosi(mosi), .miso(miso_w));
   // memory model: one cycle read latency, writes logged
   always @(posedge core_clk) begin
      if (mem_re)
         mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
         last_addr <= mem_addr;
         last_blk <= mem_blk;
         wcnt <= wcnt + 1;
      end
   end
   task automatic hdr(input logic [15:0] a, input logic [4:0] b, input logic w,
      input logic [1:0] om);
      sfsp_master_inst.xfer(a[15:8], 8, rx);
      sfsp_master_inst.xfer(a[7:0], 8, rx);
      sfsp_master_inst.xfer({b, w, om}, 8, rx);
   endtask
   // fixed write of 4 across a carry, then fixed read of 2, select held low
   task automatic t_fixed();
      idle_lvl = 1'b0;
      sfsp_master_inst.sel(idle_lvl);
      hdr(16'h34FE, 5'h1D, 1'b1, sfsp_pkg::OM_FIX4);
      for (int i = 0; i < 4; i++)
         sfsp_master_inst.xfer(8'(8'h11 * (i + 1)), 8, rx);
      hdr(16'h0040, 5'h05, sfsp_pkg::RW_READ, sfsp_pkg::OM_FIX2);
      // the last control bit needs the sync stages before the block lands
      repeat (4) @(posedge core_clk);
      `CHK(mem_blk, 5'h05)
      for (int i = 0; i < 2; i++) begin
         sfsp_master_inst.xfer(8'h00, 8, rx);
         `CHK(rx, 8'(8'h40 + i) ^ 8'hA5)
      end
      `CHK(miso_oe, 1'b1)
      sfsp_master_inst.desel(idle_lvl);
      // chip select passes two sync stages before the output is released
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 4; i++)
         `CHK(mem[8'(8'hFE + i)], 8'(8'h11 * (i + 1)))
      `CHK(wcnt, 4)
      `CHK(last_addr, 16'h3501)
      `CHK(last_blk, 5'h1D)
      `CHK(miso_oe, 1'b0)
      `CHK(miso, 1'b0)
      $display("t_fixed done");
   endtask
   // variable read of 3 in mode 3, ended by select rising
   task automatic t_var();
      idle_lvl = 1'b1;
      sfsp_master_inst.sel(idle_lvl);
      hdr(16'h0010, 5'h02, sfsp_pkg::RW_READ, sfsp_pkg::OM_VAR);
      for (int i = 0; i < 3; i++) begin
         sfsp_master_inst.xfer(8'h00, 8, rx);
         `CHK(rx, 8'(8'h10 + i) ^ 8'hA5)
      end
      sfsp_master_inst.desel(idle_lvl);
      `CHK(wcnt, 4)
      $display("t_var done");
   endtask
   // select rises after 12 bits; the next frame must start afresh
   task automatic t_abort();
      idle_lvl = 1'b0;
      sfsp_master_inst.sel(idle_lvl);
      sfsp_master_inst.xfer(8'h12, 8, rx);
      sfsp_master_inst.xfer(8'h34, 4, rx);
      sfsp_master_inst.desel(idle_lvl);
      sfsp_master_inst.sel(idle_lvl);
      hdr(16'h0080, 5'h08, 1'b1, sfsp_pkg::OM_FIX1);
      sfsp_master_inst.xfer(8'h5A, 8, rx);
      sfsp_master_inst.desel(idle_lvl);
      `CHK(wcnt, 5)
      `CHK(last_addr, 16'h0080)
      `CHK(mem[8'h80], 8'h5A)
      $display("t_abort done");
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'hA5;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_fixed();
      t_var();
      t_abort();
      wrap_up();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      wrap_up();
   end
endmodule // tb_spi_frame_slave_port
